// ### src/irq_map_pkg.sv
// constants and register map for the irq 81..109 source map slice
// What this block does
// [R1] each irq but 108 has offset bits 17:1, 3-bit priority, 2-bit sub-priority, flag, enable
// [R2] adc data channels 22..43 are irqs 81..102, flags 17..6, persistent
// [R3] usb suspend/resume is irq 103, bit 7, priority 28:26, non-persistent
// [R4] core performance counter is irq 104, bit 8, priority 4:2, non-persistent
// [R5] core fast debug channel is irq 105, bit 9, priority 12:10, persistent
// [R6] system bus protection violation is irq 106, bit 10, persistent
// [R7] crypto event is persistent irq 107 at bit 11; irq 108 has no bits
// [R8] spi one fault is persistent irq 109, bit 13, priority 12:10, sub 9:8
// [R9] graphics hsync and vsync interrupts are persistent after reset
// [R10] graphics type-select bit 31 switches them to non-persistent
// [R11] persistent flags re-set while source high; others set once per event
// [R12] pick highest priority, then sub-priority, then lowest irq; present offset
package irq_map_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_SLOTS = 29;
    localparam int FIRST_IRQ = 81;
    localparam int IRQ_W = 7;
    localparam int PRI_W = 3;
    localparam int SUB_W = 2;
    localparam int OFF_HI = 17;
    localparam int OFF_W = 17;
    // flag / enable word layout: irq n sits at bit n-64 of {word3, word2}
    localparam int W2_LO = 17;
    localparam int W2_SLOTS = 15;
    localparam int W3_SLOTS = 14;
    localparam int RSV_SLOT = 27;
    // 1 = persistent, slot index is irq minus 81
    localparam logic [NUM_SLOTS-1:0] PERSIST_MASK = 29'h1f3f_ffff;
    localparam logic [NUM_SLOTS-1:0] RSV_MASK = 29'h0800_0000;
    // priority field positions inside one byte lane of a priority word
    localparam int PRI_LSB = 2;
    localparam int SUB_LSB = 0;
    localparam int FIRST_PRI_WORD = 20;
    localparam int NUM_PRI_WORDS = 8;
    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] FLAG2_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] FLAG3_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] EN2_ADDR = 8'h08;
    localparam logic [ADDR_W-1:0] EN3_ADDR = 8'h0c;
    localparam logic [ADDR_W-1:0] GFX_ADDR = 8'h10;
    localparam logic [ADDR_W-1:0] ACTIVE_ADDR = 8'h14;
    localparam logic [ADDR_W-1:0] PRI_BASE = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_BASE = 8'h80;
    // graphics register fields
    localparam int GFX_TYPE_BIT = 31;
    localparam int GFX_FLAG_LSB = 0;
    localparam int GFX_EN_LSB = 8;
    // active register fields
    localparam int ACT_VALID_BIT = 31;
    localparam int ACT_PRI_LSB = 8;
endpackage

// ### src/irq_source_map.sv
// interrupt flag, enable, priority and vector selection for irqs 81..109
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module irq_source_map
    import irq_map_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic [NUM_SLOTS-1:0] src_req,
    input wire logic gfx_hsync_req,
    input wire logic gfx_vsync_req,
    output logic irq_out,
    output logic vec_valid,
    output logic [IRQ_W-1:0] vec_irq,
    output logic [OFF_HI:0] vec_offset
);
    logic [NUM_SLOTS-1:0] flag_q;
    logic [NUM_SLOTS-1:0] en_q;
    logic [NUM_SLOTS-1:0] src_q;
    logic [PRI_W-1:0] pri_q [NUM_SLOTS];
    logic [SUB_W-1:0] sub_q [NUM_SLOTS];
    logic [OFF_W-1:0] off_q [NUM_SLOTS];
    logic [1:0] gfx_flag_q;
    logic [1:0] gfx_en_q;
    logic [1:0] gfx_src_q;
    logic gfx_type_q;
    logic [DATA_W-1:0] rdata_q;
    logic vec_valid_q;
    logic [IRQ_W-1:0] vec_irq_q;
    logic [4:0] vec_idx_q;
    logic [PRI_W-1:0] vec_pri_q;
    logic [OFF_HI:0] vec_off_q;

    // write decode
    wire wr_flag2 = reg_wr && reg_addr == FLAG2_ADDR;
    wire wr_flag3 = reg_wr && reg_addr == FLAG3_ADDR;
    wire wr_en2 = reg_wr && reg_addr == EN2_ADDR;
    wire wr_en3 = reg_wr && reg_addr == EN3_ADDR;
    wire wr_gfx = reg_wr && reg_addr == GFX_ADDR;

    // write-one-to-clear mask lined up on slots
    wire [NUM_SLOTS-1:0] clr_w2 = wr_flag2 ?
        {14'h0, reg_wdata[DATA_W-1:W2_LO]} : 29'h0;
    wire [NUM_SLOTS-1:0] clr_w3 = wr_flag3 ?
        {reg_wdata[W3_SLOTS-1:0], 15'h0} : 29'h0;
    wire [NUM_SLOTS-1:0] flag_clr = clr_w2 | clr_w3;
    wire [NUM_SLOTS-1:0] en_new = {
        wr_en3 ? reg_wdata[W3_SLOTS-1:0] : en_q[NUM_SLOTS-1:W2_SLOTS],
        wr_en2 ? reg_wdata[DATA_W-1:W2_LO] : en_q[W2_SLOTS-1:0]};

    // persistent sources set on level, the rest on a rising edge
    wire [NUM_SLOTS-1:0] src_edge = src_req & ~src_q;
    wire [NUM_SLOTS-1:0] flag_set = ~RSV_MASK &
        ((PERSIST_MASK & src_req) | (~PERSIST_MASK & src_edge)); // R2 R3 R4 R5 R6 R7 R8 R11
    // set beats clear so an event in the clearing cycle survives
    wire [NUM_SLOTS-1:0] flag_d = flag_set | (flag_q & ~flag_clr); // R11
    wire [NUM_SLOTS-1:0] pend = flag_q & en_q;

    // graphics sync sources: persistent until type-select is written with a one
    wire [1:0] gfx_src = {gfx_vsync_req, gfx_hsync_req};
    wire [1:0] gfx_set = gfx_type_q ? (gfx_src & ~gfx_src_q) : gfx_src; // R9 R10
    wire [1:0] gfx_clr = wr_gfx ? reg_wdata[GFX_FLAG_LSB+1:GFX_FLAG_LSB]
        : 2'h0;
    wire [1:0] gfx_flag_d = gfx_set | (gfx_flag_q & ~gfx_clr);
    wire gfx_pend = |(gfx_flag_q & gfx_en_q);

    // slot state; clk_en freezes everything except reset
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            flag_q <= '0;
            en_q <= '0;
            src_q <= '0;
        end else if (clk_en) begin
            flag_q <= flag_d;
            en_q <= en_new & ~RSV_MASK; // R7
            src_q <= src_req;
        end
    end

    // graphics control
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            gfx_type_q <= 1'b0; // R9
            gfx_flag_q <= 2'h0;
            gfx_en_q <= 2'h0;
            gfx_src_q <= 2'h0;
        end else if (clk_en) begin
            gfx_flag_q <= gfx_flag_d;
            gfx_src_q <= gfx_src;
            if (wr_gfx) begin
                gfx_type_q <= reg_wdata[GFX_TYPE_BIT]; // R10
                gfx_en_q <= reg_wdata[GFX_EN_LSB+1:GFX_EN_LSB];
            end
        end
    end

    // per-slot priority and offset storage; byte lane b = slot + 1
    logic [7:0] pri_byte [NUM_PRI_WORDS*4];
    assign pri_byte[0] = 8'h0;
    assign pri_byte[NUM_PRI_WORDS*4-2] = 8'h0;
    assign pri_byte[NUM_PRI_WORDS*4-1] = 8'h0;
    for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
        localparam int B = s + 1;
        localparam int LANE = (B % 4) * 8;
        localparam logic [ADDR_W-1:0] PADDR = PRI_BASE + 8'((B / 4) * 4);
        localparam logic [ADDR_W-1:0] OADDR = OFF_BASE + 8'(s * 4);
        wire wr_pri = reg_wr && reg_addr == PADDR;
        wire wr_off = reg_wr && reg_addr == OADDR;
        if (s == RSV_SLOT) begin : g_rsv
            // reserved irq keeps no priority or offset storage
            assign pri_q[s] = '0; // R7
            assign sub_q[s] = '0;
            assign off_q[s] = '0;
        end else begin : g_live
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    pri_q[s] <= '0;
                    sub_q[s] <= '0;
                    off_q[s] <= '0;
                end else if (clk_en) begin
                    if (wr_pri) begin
                        pri_q[s] <= reg_wdata[LANE+PRI_LSB +: PRI_W]; // R1
                        sub_q[s] <= reg_wdata[LANE+SUB_LSB +: SUB_W]; // R1
                    end
                    if (wr_off) begin
                        off_q[s] <= reg_wdata[OFF_HI:1]; // R1
                    end
                end
            end
        end
        assign pri_byte[B] = {3'h0, pri_q[s], sub_q[s]};
    end

    // priority words assembled from four byte lanes each
    logic [DATA_W-1:0] pri_word [NUM_PRI_WORDS];
    for (genvar w = 0; w < NUM_PRI_WORDS; w++) begin : g_pword
        assign pri_word[w] = {pri_byte[4*w+3], pri_byte[4*w+2],
            pri_byte[4*w+1], pri_byte[4*w]};
    end

    // arbitration: strict greater-than keeps the lowest irq on a tie
    logic found;
    logic [4:0] best_idx;
    logic [PRI_W+SUB_W-1:0] best_key;
    always_comb begin
        found = 1'b0;
        best_idx = 5'h0;
        best_key = '0;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            if (pend[i] && (!found || {pri_q[i], sub_q[i]} > best_key)) begin
                found = 1'b1; // R12
                best_idx = 5'(i);
                best_key = {pri_q[i], sub_q[i]};
            end
        end
    end

    // registered vector towards the core, one cycle behind the flags
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            vec_valid_q <= 1'b0;
            vec_idx_q <= 5'h0;
            vec_irq_q <= '0;
            vec_pri_q <= '0;
            vec_off_q <= '0;
        end else if (clk_en) begin
            vec_valid_q <= found; // R12
            vec_idx_q <= best_idx;
            vec_irq_q <= IRQ_W'(FIRST_IRQ) + IRQ_W'(best_idx);
            vec_pri_q <= best_key[PRI_W+SUB_W-1:SUB_W];
            vec_off_q <= {off_q[best_idx], 1'b0}; // R1 R12
        end
    end

    // read decode
    wire [ADDR_W-1:0] off_rel = reg_addr - OFF_BASE;
    wire [5:0] off_idx = off_rel[7:2];
    wire hit_pri = reg_addr[7:5] == PRI_BASE[7:5] && reg_addr[1:0] == 2'h0;
    wire hit_off = reg_addr >= OFF_BASE && reg_addr[1:0] == 2'h0 &&
        off_idx < 6'(NUM_SLOTS);
    wire [63:0] flag_map = {18'h0, flag_q, 17'h0};
    wire [63:0] en_map = {18'h0, en_q, 17'h0};
    wire [DATA_W-1:0] gfx_word = {gfx_type_q, 21'h0, gfx_en_q, 6'h0,
        gfx_flag_q};
    wire [DATA_W-1:0] act_word = {vec_valid_q, 20'h0, vec_pri_q, 1'h0,
        vec_irq_q};
    wire [DATA_W-1:0] off_word = hit_off ?
        {14'h0, off_q[off_idx[4:0]], 1'b0} : 32'h0;
    wire [DATA_W-1:0] rd_mux =
        reg_addr == FLAG2_ADDR ? flag_map[31:0] :
        reg_addr == FLAG3_ADDR ? flag_map[63:32] :
        reg_addr == EN2_ADDR ? en_map[31:0] :
        reg_addr == EN3_ADDR ? en_map[63:32] :
        reg_addr == GFX_ADDR ? gfx_word :
        reg_addr == ACTIVE_ADDR ? act_word :
        hit_pri ? pri_word[reg_addr[4:2]] : off_word;

    // read data valid only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata_q <= '0;
        end else if (clk_en) begin
            rdata_q <= reg_rd ? rd_mux : 32'h0;
        end
    end

    assign reg_rdata = rdata_q;
    assign irq_out = |pend || gfx_pend;
    assign vec_valid = vec_valid_q;
    assign vec_irq = vec_irq_q;
    assign vec_offset = vec_off_q;

    // no pending slot may outrank the chosen one
    logic beaten;
    always_comb begin
        beaten = 1'b0;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            if (pend[i] && {pri_q[i], sub_q[i]} > best_key) begin
                beaten = 1'b1;
            end
        end
    end

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    adc_persist_a: assert property ( // R2
        clk_en && src_req[0] |=> flag_q[0])
        else $error("adc slot flag not set while source high");
    usb_once_a: assert property ( // R3
        clk_en && src_q[22] && src_req[22] && !flag_q[22] |=> !flag_q[22])
        else $error("usb flag set again by held level");
    perf_once_a: assert property ( // R4
        clk_en && src_q[23] && src_req[23] && !flag_q[23] |=> !flag_q[23])
        else $error("perf counter flag set by held level");
    debug_persist_a: assert property ( // R5
        clk_en && src_req[24] && wr_flag3 |=> flag_q[24])
        else $error("debug channel flag lost on clear");
    bus_persist_a: assert property ( // R6
        clk_en && src_req[25] |=> flag_q[25])
        else $error("bus violation flag not set");
    rsv_empty_a: assert property ( // R7
        !flag_q[RSV_SLOT] && !en_q[RSV_SLOT] && pri_byte[28] == 8'h0)
        else $error("reserved irq holds state");
    spi_persist_a: assert property ( // R8
        clk_en && src_req[28] |=> flag_q[28])
        else $error("spi fault flag not set");
    gfx_reset_a: assert property ( // R9
        $fell(reset) |-> !gfx_type_q)
        else $error("graphics type not persistent after reset");
    gfx_type_a: assert property ( // R10
        clk_en && wr_gfx |=> gfx_type_q == $past(reg_wdata[GFX_TYPE_BIT]))
        else $error("graphics type select not taken");
    clr_keep_a: assert property ( // R11
        clk_en && flag_q[3] && src_req[3] && wr_flag2 |=> flag_q[3])
        else $error("persistent flag cleared while source high");
    vec_pick_a: assert property ( // R12
        clk_en && |pend |=> vec_valid_q &&
            vec_idx_q == $past(best_idx) && $past(pend[best_idx]) &&
            vec_off_q == {$past(off_q[best_idx]), 1'b0})
        else $error("vector not from a pending enabled irq");
    vec_tie_a: assert property ( // R12
        clk_en && pend == 29'h1000_0001 &&
            {pri_q[0], sub_q[0]} == {pri_q[28], sub_q[28]}
            |=> vec_irq_q == 7'h51)
        else $error("tie not broken to lower irq");

    // adc range end and the crypto slot are level-set as well
    adc_last_a: assert property ( // R2
        clk_en && src_req[21] |=> flag_q[21])
        else $error("last adc slot flag not set");
    crypto_persist_a: assert property ( // R7
        clk_en && src_req[26] |=> flag_q[26])
        else $error("crypto flag not set while source high");

    // non-persistent sources still catch the first edge
    usb_edge_a: assert property ( // R3
        clk_en && src_edge[22] |=> flag_q[22])
        else $error("usb event edge lost");
    perf_edge_a: assert property ( // R4
        clk_en && src_edge[23] |=> flag_q[23])
        else $error("perf counter edge lost");

    // bus violation and spi flags survive a clear while high
    bus_clr_a: assert property ( // R6
        clk_en && src_req[25] && wr_flag3 |=> flag_q[25])
        else $error("bus violation flag lost on clear");
    spi_clr_a: assert property ( // R8
        clk_en && src_req[28] && wr_flag3 |=> flag_q[28])
        else $error("spi fault flag lost on clear");

    // graphics flags follow the type select
    gfx_level_a: assert property ( // R9
        clk_en && !gfx_type_q && gfx_src[0] |=> gfx_flag_q[0])
        else $error("graphics flag not re-set in persistent mode");
    gfx_edge_a: assert property ( // R10
        clk_en && gfx_type_q && gfx_src_q[0] && gfx_src[0] &&
            !gfx_flag_q[0] |=> !gfx_flag_q[0])
        else $error("graphics flag re-set in edge mode");

    // arbitration picks the best key and the vector follows it
    vec_best_a: assert property ( // R12
        found |-> !beaten)
        else $error("a pending irq outranks the chosen one");
    vec_idle_a: assert property ( // R12
        clk_en && !found |=> !vec_valid_q)
        else $error("vector valid with nothing pending");
    vec_range_a: assert property ( // R12
        vec_valid_q |-> vec_irq_q >= 7'h51 && vec_irq_q <= 7'h6d &&
            vec_irq_q != 7'h6c)
        else $error("vector outside the mapped irqs");

    // enable word lands as written, reserved bit forced low
    en_write_a: assert property ( // R1
        clk_en && wr_en3 |=> en_q[NUM_SLOTS-1:W2_SLOTS] ==
            ($past(reg_wdata[W3_SLOTS-1:0]) & 14'h2fff))
        else $error("enable word 3 not taken");

    // offset writes keep bits 17:1 only
    off_write_a: assert property ( // R1
        clk_en && reg_wr && reg_addr == OFF_BASE |=>
            off_q[0] == $past(reg_wdata[OFF_HI:1]))
        else $error("offset of first irq not taken");

    // read data stands one cycle and is zero between reads
    rd_idle_a: assert property ( // R1
        clk_en && !reg_rd |=> reg_rdata == 32'h0)
        else $error("read data left standing");

    // a low clock enable freezes flags, enables and the vector
    freeze_a: assert property ( // R1
        !clk_en |=> $stable(flag_q) && $stable(en_q) &&
            $stable(vec_valid_q))
        else $error("state moved under a low clock enable");

    usb_event_c: cover property (clk_en && src_edge[22] ##1 flag_q[22]);
    two_pending_c: cover property (pend[0] && pend[28] ##1 vec_valid_q);
    gfx_switch_c: cover property (wr_gfx && reg_wdata[GFX_TYPE_BIT]);
    clear_race_c: cover property (clk_en && |(flag_set & flag_clr));
    gfx_edge_c: cover property (gfx_type_q && gfx_src_q[0] &&
        !gfx_flag_q[0]);
endmodule

// ### sim/core_model.sv
// processor core model that takes the presented vector
`timescale 1ns/1ps
module core_model
    import irq_map_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic vec_valid,
    input wire logic [IRQ_W-1:0] vec_irq,
    input wire logic [OFF_HI:0] vec_offset,
    output logic [IRQ_W-1:0] taken_irq,
    output logic [OFF_HI:0] taken_off
);
    // no vector shows all ones, so a stale value cannot pass
    always @(posedge ref_clk) begin
        if (reset || !vec_valid) begin
            taken_irq <= '1;
            taken_off <= '1;
        end else begin
            taken_irq <= vec_irq;
            taken_off <= vec_offset;
        end
    end
endmodule

// ### sim/irq_source_map_tb.sv
// self-checking bench for the irq 81..109 source map
`timescale 1ns/1ps
module irq_source_map_tb;
    import irq_map_pkg::*;
    logic ref_clk = 0, reset = 1, clk_en = 1, reg_wr = 0, reg_rd = 0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
    logic [NUM_SLOTS-1:0] src_req = '0;
    logic hs = 0, vs = 0, irq_out, vec_valid, rd_seen = 0;
    logic [IRQ_W-1:0] vec_irq, taken_irq;
    logic [OFF_HI:0] vec_offset, taken_off;
    logic [31:0] expq[$];
    logic [31:0] off[NUM_SLOTS];
    int miscompares = 0, checks = 0, cyc_n = 0;
    int tab[4][5] = '{'{2, 0, 5, 0, 109}, '{2, 0, 2, 1, 109},
        '{3, 0, 2, 3, 81}, '{2, 1, 2, 1, 81}};
    irq_source_map dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_req(src_req),
        .gfx_hsync_req(hs), .gfx_vsync_req(vs), .irq_out(irq_out),
        .vec_valid(vec_valid), .vec_irq(vec_irq), .vec_offset(vec_offset));
    core_model core (.ref_clk(ref_clk), .reset(reset),
        .vec_valid(vec_valid), .vec_irq(vec_irq), .vec_offset(vec_offset),
        .taken_irq(taken_irq), .taken_off(taken_off));
    always #5 ref_clk = ~ref_clk;
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wr(logic [ADDR_W-1:0] a, logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 0;
    endtask
    // the note goes on the queue, the watcher compares it next cycle
    task automatic rd(logic [ADDR_W-1:0] a, logic [31:0] e);
        @(posedge ref_clk);
        reg_rd <= 1;
        reg_addr <= a;
        expq.push_back(e);
        @(posedge ref_clk);
        reg_rd <= 0;
    endtask
    // the extra 1 ns lets the edge's updates land before sampling
    task automatic cyc(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // read data stands only in the cycle after the strobe
    always @(posedge ref_clk) begin
        rd_seen <= reg_rd && clk_en;
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            miscompares++;
            close_out();
        end
    end
    // compared mid-cycle, clear of the edge that launches or drops it
    always @(negedge ref_clk) begin
        if (rd_seen) begin
            chk("reg_rdata", reg_rdata, expq.pop_front());
        end
    end
    initial begin
        void'($urandom(32'habf4));
        repeat (20) @(posedge ref_clk);
        reset <= 0;
        rd(GFX_ADDR, 0);
        rd(8'h18, 0);
        wr(EN2_ADDR, 32'hffff_ffff);
        wr(EN3_ADDR, 32'hffff_ffff);
        rd(EN3_ADDR, 32'h0000_2fff);
        // a strobe under a low clock enable is dropped
        clk_en <= 0;
        wr(EN2_ADDR, 0);
        clk_en <= 1;
        rd(EN2_ADDR, 32'hfffe_0000);
        for (int i = 0; i < NUM_SLOTS; i++) begin
            off[i] = $urandom;
            wr(OFF_BASE + 8'(4 * i), off[i]);
            off[i] = (i == 27) ? 0 : off[i] & 32'h0003_fffe;
            rd(OFF_BASE + 8'(4 * i), off[i]);
        end
        // only lanes of mapped irqs keep their 5 priority bits
        for (int w = 0; w < NUM_PRI_WORDS; w++) begin
            logic [31:0] d, m;
            int n;
            d = $urandom;
            m = 0;
            for (int l = 0; l < 4; l++) begin
                n = 4 * (w + 20) + l;
                if (n inside {[81:107], 109}) m |= 32'h1f << (8 * l);
            end
            wr(PRI_BASE + 8'(4 * w), d);
            rd(PRI_BASE + 8'(4 * w), d & m);
        end
        // each source: own flag bit, vector, then clear under a held source
        for (int i = 0; i < NUM_SLOTS; i++) begin
            logic [63:0] m;
            logic [ADDR_W-1:0] a;
            logic [31:0] d;
            m = 64'h1 << (i + 17);
            a = (i < 15) ? FLAG2_ADDR : FLAG3_ADDR;
            d = (i == 27) ? 0 : (i < 15) ? m[31:0] : m[63:32];
            src_req <= 29'h1 << i;
            cyc(3);
            chk("irq_out", irq_out, d != 0);
            chk("vec_valid", vec_valid, d != 0);
            if (d != 0) begin
                chk("vec_irq", vec_irq, 81 + i);
                chk("taken_irq", taken_irq, 81 + i);
                chk("taken_off", taken_off, off[i]);
            end
            wr(a, d);
            rd(a, (i inside {22, 23}) ? 0 : d);
            src_req <= 0;
            wr(a, d);
            rd(a, 0);
        end
        // masking hides a pending flag, unmasking shows it again
        src_req <= 29'h1;
        wr(EN2_ADDR, 0);
        cyc(2);
        chk("irq_out", irq_out, 0);
        chk("vec_valid", vec_valid, 0);
        rd(FLAG2_ADDR, 32'h0002_0000);
        wr(EN2_ADDR, 32'hfffe_0000);
        cyc(1);
        chk("irq_out", irq_out, 1);
        // priority first, then sub-priority, then the lower irq
        for (int k = 0; k < 4; k++) begin
            wr(PRI_BASE, 32'(tab[k][0]) << 10 | 32'(tab[k][1]) << 8);
            wr(PRI_BASE + 8'h1c, 32'(tab[k][2]) << 10 | 32'(tab[k][3]) << 8);
            src_req <= 29'h1000_0001;
            cyc(3);
            chk("vec_irq", vec_irq, tab[k][4]);
            rd(ACTIVE_ADDR, 32'h8000_0000 | 32'(tab[k][4]) |
                32'(tab[k][4] == 81 ? tab[k][0] : tab[k][2]) << 8);
        end
        src_req <= 0;
        wr(FLAG2_ADDR, 32'h0002_0000);
        wr(FLAG3_ADDR, 32'h0000_2000);
        cyc(1);
        chk("irq_out", irq_out, 0);
        // graphics sync flags re-set until the type bit is set
        for (int g = 0; g < 2; g++) begin
            @(posedge ref_clk);
            hs <= (g == 0);
            vs <= (g == 1);
            wr(GFX_ADDR, 32'h0000_0300 | 32'h1 << g);
            rd(GFX_ADDR, 32'h0000_0300 | 32'h1 << g);
            cyc(0);
            chk("irq_out", irq_out, 1);
            wr(GFX_ADDR, 32'h8000_0300);
            wr(GFX_ADDR, 32'h8000_0300 | 32'h1 << g);
            rd(GFX_ADDR, 32'h8000_0300);
            hs <= 0;
            vs <= 0;
            wr(GFX_ADDR, 0);
        end
        cyc(2);
        close_out();
    end
endmodule
